/* File: include/fault_action_cfg.svh */
// offsets, field positions, reset values and timing counts
`ifndef FAULT_ACTION_CFG_SVH
`define FAULT_ACTION_CFG_SVH

`define CLK_PERIOD_NS 4
`define QUAL_STEP_NS 100
`define QUAL_STEP_CYC ((`QUAL_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ADDR_W 8
`define OFS_CONFIG 8'h00
`define OFS_MASK 8'h04
`define OFS_DIAG1 8'h08
`define OFS_DIAG2 8'h0c
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_STATE 8'h18

`define CODE_W 6
`define CODE_MAX 63
`define CFG_STOP_ALL_BIT 0
`define CFG_WD_EN_BIT 1
`define CFG_QMODE_BIT 2
`define CFG_TVD_LSB 8
`define CFG_VTH_LSB 16
`define CFG_VTL_LSB 24
`define TVD_RESET 6'h0f
`define VTH_RESET 6'h10
`define VTL_RESET 6'h10

`define MASK_W 12
`define MSK_VDS 0
`define MSK_BS 1
`define MSK_GATE_REGULATOR_OUTPUT_UV 2
`define MSK_VBB_UV 3
`define MSK_LOGIC_OV 4
`define MSK_WD 5

`define PIN_W 19
`define PIN_RESET 19'h40000
`define PIN_VDS 0
`define PIN_BS 4
`define PIN_GATE_REGULATOR_OUTPUT_UV 6
`define PIN_VBB_UV 7
`define PIN_LOGIC_OV 8
`define PIN_OT 9
`define PIN_WD 10
`define PIN_CLR 18

`define DIAG2_W 14
`define D2_WD 6

`define IRQ_W 4
`define IRQ_VDS 0
`define IRQ_BS 1
`define IRQ_OTHER 2
`define IRQ_ALL_OFF 3

`define GATE_W 4

`endif

/* File: include/fault_action_pkg.sv */
// types shared by the fault action logic
package fault_action_pkg;
    typedef enum logic {QUAL_DEBOUNCE, QUAL_BLANKING} qual_mode_t;
    typedef logic [3:0] gate_vec_t;
endpackage

/* File: include/qual_if.sv */
// one comparator channel between control and its qualifier
`timescale 1ns/1ps
interface qual_if;
    logic cmp;
    logic gate_on;
    logic turn_on;
    logic valid;
    modport qual (input cmp, input gate_on, input turn_on, output valid);
    modport ctl (output cmp, output gate_on, output turn_on, input valid);
endinterface

/* File: logic/vds_qualifier.sv */
// drain-source fault qualifier: debounce or blanking timer
`timescale 1ns/1ps
`include "fault_action_cfg.svh"
module vds_qualifier
    import fault_action_pkg::*;
#(
    parameter int CNT_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input qual_mode_t mode,
    input wire logic [CNT_W-1:0] limit,
    qual_if.qual q
);
    logic [CNT_W-1:0] cnt_ff;
    logic valid_ff;
    logic expired;
    logic active;

    if (CNT_W < 1) begin : g_bad_width
        $error("vds_qualifier: CNT_W must be at least 1");
    end

    assign expired = (cnt_ff >= limit);
    assign active = q.cmp & q.gate_on;
    assign q.valid = valid_ff;

    // one counter serves both modes; mode change restarts nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else if (clk_en) begin
            if (mode == QUAL_DEBOUNCE) begin
                if (!active) begin
                    cnt_ff <= '0;
                end else if (!expired) begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end else begin
                if (q.turn_on) begin
                    cnt_ff <= '0;
                end else if (!expired) begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_ff <= 1'b0;
        end else if (clk_en) begin
            if (mode == QUAL_DEBOUNCE) begin
                valid_ff <= active & expired;
            end else begin
                valid_ff <= active & ~q.turn_on & expired;
            end
        end
    end
endmodule // vds_qualifier

/* File: logic/bridge_fault_action_logic.sv */
// fault action logic for a full-bridge gate driver with APB registers
// Operation
// - low-side drain-source fault sets its diag bit, turns that low side off
// - high-side drain-source fault sets its diag bit, turns that high side off
// - in blanking mode comparator ignored while the blanking timer runs
// - stop-all-on-fault set: any drain-source fault turns every gate off
// - shorted winding reported through the same high and low detectors
// - reset or regulator undervoltage forces all gates low, not latched
// - watchdog enabled and timed out: all gates low until timer restart
// - logic overvoltage or overtemp turn all off only when stop-all set
// - drain-source or bootstrap fault with stop-all: all off and latched
// - without stop-all: only affected gate off, latch cleared on turn-on
// - non-latched fault states release as soon as detection ends
// - latched states cleared by clear pin low, reset, or diag read
// - diag bits cleared only by reset or read, never by clear pin
// - other faults leave the gate outputs enabled
// - every diagnostic but reset, serial error, overtemp is maskable
// - masked diagnostic makes no fault state and sets no diag bit
// - qualify time is six-bit code times one hundred nanoseconds
// - debounce default restarts on each fault, valid when timer expires
// - high and low trip levels come from six-bit codes
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "fault_action_cfg.svh"
module bridge_fault_action_logic
    import fault_action_pkg::*;
#(
    parameter int QUAL_CNT_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [`GATE_W-1:0] gate_cmd,
    input wire logic wd_restart,
    input wire logic [`GATE_W-1:0] vds_cmp,
    input wire logic [1:0] bootstrap_uv,
    input wire logic gate_regulator_output_uv,
    input wire logic vbb_uv,
    input wire logic logic_ov,
    input wire logic overtemp,
    input wire logic wd_timeout,
    input wire logic serial_err,
    input wire logic gate_regulator_output_ov,
    input wire logic vbb_ov,
    input wire logic vgs_uv,
    input wire logic temp_warn,
    input wire logic overcurrent,
    input wire logic open_load,
    input wire logic fault_clear_low_pin,
    output logic [`GATE_W-1:0] gate_out,
    output logic [`CODE_W-1:0] high_side_threshold_code,
    output logic [`CODE_W-1:0] low_side_threshold_code
);
    // longest qualify time must fit the qualifier counter
    if ((2 ** QUAL_CNT_W) - 1 < `CODE_MAX * `QUAL_STEP_CYC) begin : g_bad
        $error("QUAL_CNT_W too small for the longest qualify time");
    end

    logic [`PIN_W-1:0] raw;
    logic [`PIN_W-1:0] s1_ff;
    logic [`PIN_W-1:0] s2_ff;
    logic [`PIN_W-1:0] s3_ff;
    logic [`PIN_W-1:0] filt_ff;
    logic stop_all_on_fault_ff;
    logic enable_watchdog_monitor_ff;
    qual_mode_t qualifier_mode_select_ff;
    logic [`CODE_W-1:0] qualify_time_code_ff;
    logic [`CODE_W-1:0] high_code_ff;
    logic [`CODE_W-1:0] low_code_ff;
    logic [`MASK_W-1:0] mask_ff;
    logic [`GATE_W-1:0] diag1_ff;
    logic [`DIAG2_W-1:0] diag2_ff;
    logic [`IRQ_W-1:0] irq_st_ff;
    logic [`IRQ_W-1:0] irq_msk_ff;
    logic irq_ff;
    logic [`GATE_W-1:0] vds_lat_ff;
    logic [1:0] bs_lat_ff;
    logic wd_lat_ff;
    logic all_off_ff;
    logic [`GATE_W-1:0] gate_out_ff;
    logic [`GATE_W-1:0] cmd_prev_ff;
    logic [31:0] prdata_ff;
    logic err_ff;
    logic [31:0] nxt_rdata;
    logic nxt_err;
    logic [QUAL_CNT_W-1:0] qual_limit;
    logic [`GATE_W-1:0] turn_on;
    logic [`GATE_W-1:0] vds_valid;
    logic [`DIAG2_W-1:0] m2;
    logic [`DIAG2_W-1:0] det2;
    logic [1:0] bs_det;
    logic [`GATE_W-1:0] own_kill;
    logic [`GATE_W-1:0] bs_gate;
    logic all_kill;
    logic latch_kill;
    logic clr_pin;
    logic setup;
    logic access;
    logic wr_ok;
    logic rd_ok;
    logic rd_diag1;
    logic rd_diag2;
    logic w1c_irq;

    // pins from the analog side; fault_clear_low_pin idles high
    assign raw = {fault_clear_low_pin, open_load, overcurrent, temp_warn,
                  vgs_uv, vbb_ov, gate_regulator_output_ov, serial_err, wd_timeout,
                  overtemp, logic_ov, vbb_uv, gate_regulator_output_uv, bootstrap_uv,
                  vds_cmp};

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= `PIN_RESET;
            s2_ff <= `PIN_RESET;
            s3_ff <= `PIN_RESET;
            filt_ff <= `PIN_RESET;
        end else if (clk_en) begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= ((s2_ff ~^ s3_ff) & s3_ff) |
                       ((s2_ff ^ s3_ff) & filt_ff);
        end
    end

    assign clr_pin = ~filt_ff[`PIN_CLR];

    // apb: zero wait states while enabled, answer prepared in setup
    assign setup = psel & ~penable;
    assign access = psel & penable & clk_en;
    assign pready = clk_en;
    assign pslverr = psel & penable & err_ff;
    assign prdata = prdata_ff;
    assign wr_ok = access & pwrite & ~err_ff;
    assign rd_ok = access & ~pwrite & ~err_ff;
    assign rd_diag1 = rd_ok & (paddr == `OFS_DIAG1);
    assign rd_diag2 = rd_ok & (paddr == `OFS_DIAG2);
    assign w1c_irq = wr_ok & (paddr == `OFS_IRQ_STATUS);

    always_comb begin
        nxt_rdata = '0;
        nxt_err = 1'b0;
        case (paddr)
            `OFS_CONFIG: begin
                nxt_rdata = {2'h0, low_code_ff, 2'h0, high_code_ff, 2'h0,
                             qualify_time_code_ff, 5'h00,
                             qualifier_mode_select_ff,
                             enable_watchdog_monitor_ff,
                             stop_all_on_fault_ff};
            end
            `OFS_MASK: nxt_rdata = {20'h00000, mask_ff};
            `OFS_DIAG1: nxt_rdata = {28'h0000000, diag1_ff};
            `OFS_DIAG2: nxt_rdata = {18'h00000, diag2_ff};
            `OFS_IRQ_STATUS: nxt_rdata = {28'h0000000, irq_st_ff};
            `OFS_IRQ_MASK: nxt_rdata = {28'h0000000, irq_msk_ff};
            `OFS_STATE: begin
                nxt_rdata = {20'h00000, wd_lat_ff, all_off_ff, bs_lat_ff,
                             vds_lat_ff, gate_out_ff};
            end
            default: nxt_err = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
            err_ff <= 1'b0;
        end else if (clk_en && setup) begin
            prdata_ff <= pwrite ? 32'h00000000 : nxt_rdata;
            err_ff <= nxt_err;
        end
    end

    // configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_all_on_fault_ff <= 1'b0;
            enable_watchdog_monitor_ff <= 1'b0;
            qualifier_mode_select_ff <= QUAL_DEBOUNCE;
            qualify_time_code_ff <= `TVD_RESET;
            high_code_ff <= `VTH_RESET;
            low_code_ff <= `VTL_RESET;
        end else if (wr_ok && paddr == `OFS_CONFIG) begin
            stop_all_on_fault_ff <= pwdata[`CFG_STOP_ALL_BIT];
            enable_watchdog_monitor_ff <= pwdata[`CFG_WD_EN_BIT];
            qualifier_mode_select_ff <= qual_mode_t'(pwdata[`CFG_QMODE_BIT]);
            qualify_time_code_ff <= pwdata[`CFG_TVD_LSB +: `CODE_W];
            high_code_ff <= pwdata[`CFG_VTH_LSB +: `CODE_W];
            low_code_ff <= pwdata[`CFG_VTL_LSB +: `CODE_W];
        end
    end

    assign high_side_threshold_code = high_code_ff;
    assign low_side_threshold_code = low_code_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= '0;
        end else if (wr_ok && paddr == `OFS_MASK) begin
            mask_ff <= pwdata[`MASK_W-1:0];
        end
    end

    // diag2 layout; serial error and overtemp bits cannot be masked
    assign m2 = {mask_ff[11:6], 1'b0, mask_ff[`MSK_WD], 1'b0,
                 mask_ff[`MSK_LOGIC_OV], mask_ff[`MSK_VBB_UV],
                 mask_ff[`MSK_GATE_REGULATOR_OUTPUT_UV], {2{mask_ff[`MSK_BS]}}};

    always_comb begin
        det2 = filt_ff[`PIN_BS +: `DIAG2_W] & ~m2;
        det2[`D2_WD] = det2[`D2_WD] & enable_watchdog_monitor_ff;
    end

    assign bs_det = det2[1:0];

    // qualify time: code times the 100 ns step in clock cycles
    assign qual_limit =
        QUAL_CNT_W'(qualify_time_code_ff * `QUAL_STEP_CYC);

    assign turn_on = gate_cmd & ~cmd_prev_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_prev_ff <= '0;
        end else if (clk_en) begin
            cmd_prev_ff <= gate_cmd;
        end
    end

    // one qualifier per transistor; gate order al, ah, bl, bh
    for (genvar g = 0; g < `GATE_W; g++) begin : g_qual
        qual_if qi ();
        assign qi.cmp = filt_ff[`PIN_VDS + g];
        assign qi.gate_on = gate_out_ff[g];
        assign qi.turn_on = turn_on[g];
        assign vds_valid[g] = qi.valid & ~mask_ff[`MSK_VDS];
        vds_qualifier #(
            .CNT_W(QUAL_CNT_W)
        ) u_qual (
            .pclk(pclk),
            .presetn(presetn),
            .clk_en(clk_en),
            .mode(qualifier_mode_select_ff),
            .limit(qual_limit),
            .q(qi)
        );
    end

    // diag bits: set wins over a read clear; pin does not touch them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diag1_ff <= '0;
        end else if (clk_en) begin
            diag1_ff <= vds_valid | (diag1_ff & ~(prdata_ff[3:0] &
                        {`GATE_W{rd_diag1}}));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diag2_ff <= '0;
        end else if (clk_en) begin
            diag2_ff <= det2 | (diag2_ff & ~(prdata_ff[`DIAG2_W-1:0] &
                        {`DIAG2_W{rd_diag2}}));
        end
    end

    // latched fault states; a turn-on clears only without stop-all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vds_lat_ff <= '0;
        end else if (clk_en) begin
            vds_lat_ff <= vds_valid | (vds_lat_ff &
                ~({`GATE_W{clr_pin | rd_diag1}} |
                  (turn_on & {`GATE_W{~stop_all_on_fault_ff}})));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bs_lat_ff <= '0;
        end else if (clk_en) begin
            bs_lat_ff <= bs_det | (bs_lat_ff &
                ~({2{clr_pin | rd_diag2}} |
                  ({turn_on[3], turn_on[1]} &
                   {2{~stop_all_on_fault_ff}})));
        end
    end

    // watchdog state holds until the timer is restarted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_lat_ff <= 1'b0;
        end else if (clk_en) begin
            if (det2[`D2_WD]) begin
                wd_lat_ff <= 1'b1;
            end else if (wd_restart) begin
                wd_lat_ff <= 1'b0;
            end
        end
    end

    assign bs_gate = {bs_lat_ff[1] | bs_det[1], 1'b0,
                      bs_lat_ff[0] | bs_det[0], 1'b0};

    // new detections act in the same cycle as they latch
    assign latch_kill = stop_all_on_fault_ff &
                        (|vds_lat_ff | |vds_valid | |bs_gate);

    // level faults act only while detected; wd_lat_ff and latch_kill are held
    assign all_kill = filt_ff[`PIN_GATE_REGULATOR_OUTPUT_UV] & ~mask_ff[`MSK_GATE_REGULATOR_OUTPUT_UV] |
                      filt_ff[`PIN_VBB_UV] & ~mask_ff[`MSK_VBB_UV] |
                      wd_lat_ff |
                      stop_all_on_fault_ff &
                      (filt_ff[`PIN_LOGIC_OV] & ~mask_ff[`MSK_LOGIC_OV] |
                       filt_ff[`PIN_OT]) |
                      latch_kill;

    assign own_kill = {`GATE_W{~stop_all_on_fault_ff}} &
                      (vds_lat_ff | vds_valid | bs_gate);

    // reset clears the gates; other faults never gate outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_out_ff <= '0;
        end else if (clk_en) begin
            gate_out_ff <= gate_cmd & ~({`GATE_W{all_kill}} | own_kill);
        end
    end

    assign gate_out = gate_out_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            all_off_ff <= 1'b0;
        end else if (clk_en) begin
            all_off_ff <= all_kill;
        end
    end

    // interrupts: sticky status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_ff <= '0;
        end else if (clk_en) begin
            irq_st_ff[`IRQ_VDS] <= |(vds_valid & ~diag1_ff) |
                (irq_st_ff[`IRQ_VDS] & ~(w1c_irq & pwdata[`IRQ_VDS]));
            irq_st_ff[`IRQ_BS] <= |(bs_det & ~diag2_ff[1:0]) |
                (irq_st_ff[`IRQ_BS] & ~(w1c_irq & pwdata[`IRQ_BS]));
            irq_st_ff[`IRQ_OTHER] <= |(det2[13:2] & ~diag2_ff[13:2]) |
                (irq_st_ff[`IRQ_OTHER] & ~(w1c_irq & pwdata[`IRQ_OTHER]));
            irq_st_ff[`IRQ_ALL_OFF] <= (all_kill & ~all_off_ff) |
                (irq_st_ff[`IRQ_ALL_OFF] &
                 ~(w1c_irq & pwdata[`IRQ_ALL_OFF]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_msk_ff <= '0;
        end else if (wr_ok && paddr == `OFS_IRQ_MASK) begin
            irq_msk_ff <= pwdata[`IRQ_W-1:0];
        end
    end

    // registered so the level line never glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            irq_ff <= |(irq_st_ff & irq_msk_ff);
        end
    end

    assign irq = irq_ff;
endmodule // bridge_fault_action_logic

/* File: test/fault_action_asserts.sv */
// port-level checks for the bridge fault action logic
`timescale 1ns/1ps
`include "fault_action_cfg.svh"
module fault_action_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [`GATE_W-1:0] gate_cmd,
    input wire logic wd_restart,
    input wire logic [1:0] bootstrap_uv,
    input wire logic gate_regulator_output_uv,
    input wire logic overtemp,
    input wire logic wd_timeout,
    input wire logic [`GATE_W-1:0] gate_out,
    input wire logic [`CODE_W-1:0] high_side_threshold_code
);
    // shadow of only the config and mask bits the checks need
    logic [1:0] cfg_ff;
    logic [5:0] msk_ff;
    wire wr_acc = psel && penable && pwrite && clk_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= 2'h0;
            msk_ff <= 6'h0;
        end else if (wr_acc && paddr == `OFS_CONFIG) begin
            cfg_ff <= pwdata[1:0];
        end else if (wr_acc && paddr == `OFS_MASK) begin
            msk_ff <= pwdata[5:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // eight edges cover the pin filter plus the gate register
    sequence s_gate_regulator_output_held;
        (gate_regulator_output_uv && clk_en && !msk_ff[`MSK_GATE_REGULATOR_OUTPUT_UV])[*8];
    endsequence
    sequence s_ot_held;
        (overtemp && clk_en && cfg_ff[`CFG_STOP_ALL_BIT])[*8];
    endsequence
    sequence s_wd_held;
        (wd_timeout && clk_en && cfg_ff[`CFG_WD_EN_BIT] && !wd_restart
            && !msk_ff[`MSK_WD])[*8];
    endsequence
    sequence s_bs_held;
        (bootstrap_uv[0] && clk_en && !msk_ff[`MSK_BS])[*8];
    endsequence

    a_gate_follow: assert property (
        $past(clk_en) |-> (gate_out & ~$past(gate_cmd)) == 4'h0)
        else $error("gate driven without command");
    a_gate_regulator_output_off: assert property (s_gate_regulator_output_held |-> gate_out == 4'h0)
        else $error("gates on during regulator undervoltage");
    a_ot_stop_all: assert property (s_ot_held |-> gate_out == 4'h0)
        else $error("gates on during overtemp with stop all");
    a_wd_off: assert property (s_wd_held |-> gate_out == 4'h0)
        else $error("gates on after watchdog timeout");
    a_bs_side_off: assert property (s_bs_held |-> !gate_out[1])
        else $error("high side on during bootstrap fault");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_err_data: assert property (pslverr |-> prdata == 32'h0)
        else $error("error with nonzero read data");
    a_code_write: assert property (
        !$stable(high_side_threshold_code)
            |-> $past(wr_acc && paddr == `OFS_CONFIG))
        else $error("threshold code changed without config write");
    a_reset_state: assert property ($rose(presetn) |->
        gate_out == 4'h0 && !irq && high_side_threshold_code == 6'h10)
        else $error("wrong state after reset release");
endmodule // fault_action_asserts

bind bridge_fault_action_logic fault_action_asserts u_chk (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pslverr, .irq, .gate_cmd, .wd_restart, .bootstrap_uv,
    .gate_regulator_output_uv, .overtemp, .wd_timeout, .gate_out, .high_side_threshold_code
);

/* File: test/bridge_model.sv */
// behavioural full bridge with injectable phase and winding shorts
`timescale 1ns/1ps
module bridge_model (
    input wire logic [3:0] gate_out,
    input wire logic [1:0] to_supply,
    input wire logic [1:0] to_ground,
    input wire logic winding,
    output logic [3:0] vds_cmp
);
    // a comparator only trips while its transistor conducts into a short
    assign vds_cmp[0] = gate_out[0] &
        (to_supply[0] | winding & gate_out[3]);
    assign vds_cmp[1] = gate_out[1] &
        (to_ground[0] | winding & gate_out[2]);
    assign vds_cmp[2] = gate_out[2] &
        (to_supply[1] | winding & gate_out[1]);
    assign vds_cmp[3] = gate_out[3] &
        (to_ground[1] | winding & gate_out[0]);
endmodule // bridge_model

/* File: test/tb.sv */
// self-checking bench for the bridge fault action logic
`timescale 1ns/1ps
`include "fault_action_cfg.svh"
module tb;
    logic pclk, presetn, clk_en, psel, penable, pwrite, wd_restart;
    logic wd_timeout, pready, pslverr, irq, clr_n, winding, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [3:0] gate_cmd, gate_out, vds_cmp, kill;
    logic [1:0] bs_uv, to_supply, to_ground;
    logic [6:0] oth;
    logic [5:0] hs_code, ls_code;
    int mismatches, check_count, cyc;

    bridge_fault_action_logic dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .gate_cmd(gate_cmd), .wd_restart(wd_restart), .vds_cmp(vds_cmp),
        .bootstrap_uv(bs_uv), .gate_regulator_output_uv(kill[0]), .vbb_uv(kill[1]),
        .logic_ov(kill[2]), .overtemp(kill[3]), .wd_timeout(wd_timeout),
        .serial_err(oth[0]), .gate_regulator_output_ov(oth[1]), .vbb_ov(oth[2]),
        .vgs_uv(oth[3]), .temp_warn(oth[4]), .overcurrent(oth[5]),
        .open_load(oth[6]), .fault_clear_low_pin(clr_n),
        .gate_out(gate_out), .high_side_threshold_code(hs_code),
        .low_side_threshold_code(ls_code)
    );
    bridge_model u_bridge (.gate_out(gate_out), .to_supply(to_supply),
        .to_ground(to_ground), .winding(winding), .vds_cmp(vds_cmp));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // waits for pready, however late
    task automatic apb(input logic wr,
        input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_data = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd_data, e);
    endtask

    task automatic setcfg(input logic [2:0] b, input logic [5:0] c);
        apb(1'b1, `OFS_CONFIG, {8'h10, 2'h0, c, 2'h0, c, 5'h0, b});
    endtask

    // sample on the falling edge so the gate register has settled
    task automatic gchk(input logic [3:0] g, input logic i);
        @(negedge pclk);
        chk({27'h0, irq, gate_out}, {27'h0, i, g});
        @(posedge pclk);
    endtask

    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        gate_cmd = 4'h0;
        wd_restart = 1'b0;
        wd_timeout = 1'b0;
        bs_uv = 2'h0;
        kill = 4'h0;
        oth = 7'h0;
        clr_n = 1'b1;
        to_supply = 2'h0;
        to_ground = 2'h0;
        winding = 1'b0;
        w(6);
        presetn <= 1'b1;
        w(1);
        rd(`OFS_CONFIG, 32'h10100f00);
        chk({26'h0, hs_code}, 32'h10);
        chk({26'h0, ls_code}, 32'h10);
        rd(8'h1c, 32'h0);
        chk({31'h0, err}, 32'h1);
        gate_cmd <= 4'hf;
        w(2);
        oth <= 7'h7f;
        w(10);
        gchk(4'hf, 1'b0);
        clk_en <= 1'b0;
        gate_cmd <= 4'h0;
        w(1);
        gchk(4'hf, 1'b0);
        clk_en <= 1'b1;
        gate_cmd <= 4'hf;
        oth <= 7'h0;
        for (int s = 0; s < 2; s++) begin
            setcfg({2'h0, s[0]}, 6'h01);
            for (int i = 0; i < 4; i++) begin
                kill <= 4'h1 << i;
                w(10);
                gchk((s == 1 || i < 2) ? 4'h0 : 4'hf, 1'b0);
                kill <= 4'h0;
                w(10);
                gchk(4'hf, 1'b0);
            end
        end
        rd(`OFS_DIAG2, 32'h3fbc);
        setcfg(3'h2, 6'h01);
        wd_timeout <= 1'b1;
        w(10);
        wd_timeout <= 1'b0;
        w(10);
        gchk(4'h0, 1'b0);
        wd_restart <= 1'b1;
        w(1);
        wd_restart <= 1'b0;
        w(6);
        gchk(4'hf, 1'b0);
        rd(`OFS_DIAG2, 32'h40);
        apb(1'b1, `OFS_IRQ_STATUS, 32'hf);
        setcfg(3'h0, 6'h01);
        to_supply <= 2'h1;
        w(50);
        to_supply <= 2'h0;
        w(10);
        gchk(4'he, 1'b0);
        apb(1'b1, `OFS_IRQ_MASK, 32'hf);
        gchk(4'he, 1'b1);
        rd(`OFS_IRQ_STATUS, 32'h1);
        apb(1'b1, `OFS_IRQ_STATUS, 32'h1);
        rd(`OFS_DIAG1, 32'h1);
        gchk(4'hf, 1'b0);
        rd(`OFS_DIAG1, 32'h0);
        to_ground <= 2'h2;
        w(50);
        gchk(4'h7, 1'b1);
        to_ground <= 2'h0;
        gate_cmd <= 4'h7;
        w(8);
        gate_cmd <= 4'hf;
        w(8);
        gchk(4'hf, 1'b1);
        rd(`OFS_DIAG1, 32'h8);
        apb(1'b1, `OFS_IRQ_STATUS, 32'hf);
        setcfg(3'h1, 6'h01);
        to_ground <= 2'h1;
        w(50);
        to_ground <= 2'h0;
        w(10);
        gchk(4'h0, 1'b1);
        clr_n <= 1'b0;
        w(8);
        clr_n <= 1'b1;
        w(8);
        gchk(4'hf, 1'b1);
        rd(`OFS_DIAG1, 32'h2);
        apb(1'b1, `OFS_IRQ_STATUS, 32'hf);
        apb(1'b1, `OFS_MASK, 32'h1);
        to_supply <= 2'h2;
        w(50);
        gchk(4'hf, 1'b0);
        to_supply <= 2'h0;
        rd(`OFS_DIAG1, 32'h0);
        apb(1'b1, `OFS_MASK, 32'h0);
        setcfg(3'h0, 6'h01);
        bs_uv <= 2'h1;
        w(10);
        gchk(4'hd, 1'b1);
        bs_uv <= 2'h0;
        w(8);
        rd(`OFS_DIAG2, 32'h1);
        gchk(4'hf, 1'b1);
        gate_cmd <= 4'h6;
        winding <= 1'b1;
        w(50);
        gchk(4'h0, 1'b1);
        winding <= 1'b0;
        rd(`OFS_DIAG1, 32'h6);
        gate_cmd <= 4'h0;
        setcfg(3'h4, 6'h02);
        to_supply <= 2'h1;
        gate_cmd <= 4'h1;
        w(20);
        gchk(4'h1, 1'b1);
        w(60);
        gchk(4'h0, 1'b1);
        to_supply <= 2'h0;
        end_sim();
    end
endmodule // tb
